// File: design/lwd_pkg.sv
package lwd_pkg;
    localparam int unsigned LWD_AW = 4;
    localparam int unsigned LWD_DW = 32;
    // Register indices (word addresses on the plain port)
    localparam logic [3:0] LWD_REG_LOAD   = 4'h0;
    localparam logic [3:0] LWD_REG_VALUE  = 4'h1;
    localparam logic [3:0] LWD_REG_CTRL   = 4'h2;
    localparam logic [3:0] LWD_REG_RIS    = 4'h3;
    localparam logic [3:0] LWD_REG_MIS    = 4'h4;
    localparam logic [3:0] LWD_REG_ICR    = 4'h5;
    localparam logic [3:0] LWD_REG_LOCK   = 4'h6;
    localparam logic [3:0] LWD_REG_IMASK  = 4'h7;
    // Control bits
    localparam int unsigned LWD_CTRL_EN    = 0;
    localparam int unsigned LWD_CTRL_RESEN = 1;
    localparam int unsigned LWD_CTRL_STALL = 2;
    // Status bits
    localparam int unsigned LWD_ST_TIMEOUT = 0;
    localparam int unsigned LWD_ST_SECOND  = 1;
    localparam int unsigned LWD_NEV        = 2;
    // Lock key and reset values
    localparam logic [31:0] LWD_UNLOCK_KEY = 32'h1acc_e551;
    localparam logic [31:0] LWD_LOAD_RST   = 32'hffff_ffff;
    localparam logic [31:0] LWD_ZERO       = 32'h0000_0000;
    typedef enum logic [2:0] {
        LWD_ST_IDLE  = 3'b001,
        LWD_ST_RUN   = 3'b010,
        LWD_ST_ARMED = 3'b100
    } lwd_state_t;
endpackage

// File: design/lwd_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lwd_ctl_if;
    import lwd_pkg::*;
    logic              locked;
    logic              wr_ok;
    logic [LWD_DW-1:0] rdata;
    modport lock (output locked, output wr_ok, output rdata);
    modport core (input locked, input wr_ok, input rdata);
endinterface
`default_nettype wire

// File: design/lwd_lock.sv
`timescale 1ns/1ps
`default_nettype none
module lwd_lock
    import lwd_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Register port slice
    input  wire logic [LWD_AW-1:0] addr,
    input  wire logic [LWD_DW-1:0] wdata,
    input  wire logic              wr,
    // To core
    lwd_ctl_if.lock                ctl
);
    import lwd_pkg::*;

    logic locked_r;

    // Key opens, any other value closes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            locked_r <= 1'b0;
        end else if (wr && addr == LWD_REG_LOCK) begin
            locked_r <= (wdata != LWD_UNLOCK_KEY);
        end
    end

    assign ctl.locked = locked_r;
    assign ctl.wr_ok  = wr && !locked_r && addr != LWD_REG_LOCK;
    assign ctl.rdata  = {{(LWD_DW-1){1'b0}}, locked_r};

    AST_LOCK_BLOCK: assert property (@(posedge clk) disable iff (!rst_b)
        locked_r |-> !ctl.wr_ok) else $error("write passed while locked");
    AST_LOCK_KEY: assert property (@(posedge clk) disable iff (!rst_b)
        wr && addr == LWD_REG_LOCK && wdata == LWD_UNLOCK_KEY |=> !locked_r)
        else $error("key did not unlock");
endmodule
`default_nettype wire

// File: design/lwd_top.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Lock engaged: configuration writes ignored
// - Lock released: writes accepted again
// - Lock state readable
// - Reload loaded on first zero
// - Reload write while running loads counter
// - Zero reload raises interrupt at once
// - Reload value readable
// - Reset enable gates second-timeout reset
// - Running state readable
// - No stall: counts through debug halt
// - Stall: freezes during debug halt
// - Counter value readable any time
// - Enable starts counter and interrupt
// - Clear drops interrupt, ignored when locked
// - Raw and masked status readable
module lwd_top
    import lwd_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Register port
    input  wire logic [LWD_AW-1:0] addr,
    input  wire logic [LWD_DW-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [LWD_DW-1:0] rdata,
    // System
    input  wire logic              dbg_halt,
    output logic                   irq,
    output logic                   cpu_reset
);
    import lwd_pkg::*;

    lwd_ctl_if ctl ();

    lwd_lock u_lock (
        .clk   (clk),
        .rst_b (rst_b),
        .addr  (addr),
        .wdata (wdata),
        .wr    (wr),
        .ctl   (ctl)
    );

    logic [LWD_DW-1:0]  load_r;
    logic [LWD_DW-1:0]  cnt_r;
    logic               en_r;
    logic               resen_r;
    logic               stall_r;
    logic [LWD_NEV-1:0] ris_r;
    logic [LWD_NEV-1:0] mask_r;
    logic               rst_out_r;
    lwd_state_t         st_r;
    lwd_state_t         st_nxt;

    logic wr_load;
    logic wr_ctrl;
    logic wr_icr;
    logic wr_mask;
    logic tick;
    logic at_zero;
    logic first_to;
    logic second_to;
    logic zero_load;

    assign wr_load = ctl.wr_ok && addr == LWD_REG_LOAD;
    assign wr_ctrl = ctl.wr_ok && addr == LWD_REG_CTRL;
    assign wr_icr  = ctl.wr_ok && addr == LWD_REG_ICR;
    assign wr_mask = ctl.wr_ok && addr == LWD_REG_IMASK;

    assign tick    = en_r && !(stall_r && dbg_halt);
    assign at_zero = tick && cnt_r == LWD_ZERO;
    assign first_to  = at_zero && !ris_r[LWD_ST_TIMEOUT];
    assign second_to = at_zero && ris_r[LWD_ST_TIMEOUT];
    assign zero_load = wr_load && wdata == LWD_ZERO;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            load_r <= LWD_LOAD_RST;
        end else if (wr_load) begin
            load_r <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            en_r    <= 1'b0;
            resen_r <= 1'b0;
            stall_r <= 1'b0;
        end else if (wr_ctrl) begin
            en_r    <= en_r | wdata[LWD_CTRL_EN];
            resen_r <= wdata[LWD_CTRL_RESEN];
            stall_r <= wdata[LWD_CTRL_STALL];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_r <= LWD_LOAD_RST;
        end else if (wr_load && (en_r || st_r == LWD_ST_IDLE)) begin
            cnt_r <= wdata;
        end else if (at_zero) begin
            cnt_r <= load_r;
        end else if (tick) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ris_r <= '0;
        end else begin
            ris_r[LWD_ST_TIMEOUT] <= first_to || zero_load || second_to ||
                (ris_r[LWD_ST_TIMEOUT] && !(wr_icr && wdata[LWD_ST_TIMEOUT]));
            ris_r[LWD_ST_SECOND]  <= second_to ||
                (ris_r[LWD_ST_SECOND] && !(wr_icr && wdata[LWD_ST_SECOND]));
        end
    end

    // Mask resets open so enable alone arms the interrupt
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mask_r <= {LWD_NEV{1'b1}};
        end else if (wr_mask) begin
            mask_r <= wdata[LWD_NEV-1:0];
        end
    end

    // Sequence state; only its idle phase is used, letting reload writes load the counter before enable
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            LWD_ST_IDLE:  if (en_r) st_nxt = LWD_ST_RUN;
            LWD_ST_RUN:   if (ris_r[LWD_ST_TIMEOUT]) st_nxt = LWD_ST_ARMED;
            LWD_ST_ARMED: if (!ris_r[LWD_ST_TIMEOUT]) st_nxt = LWD_ST_RUN;
            default:      st_nxt = LWD_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= LWD_ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // reset only when enabled; held until chip reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rst_out_r <= 1'b0;
        end else if (second_to && resen_r) begin
            rst_out_r <= 1'b1;
        end
    end

    assign irq       = |(ris_r & mask_r) && (en_r || ris_r[LWD_ST_TIMEOUT]);
    assign cpu_reset = rst_out_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                LWD_REG_LOAD:  rdata <= load_r;
                LWD_REG_VALUE: rdata <= cnt_r;
                LWD_REG_CTRL:  rdata <= {29'h0, stall_r, resen_r, en_r};
                LWD_REG_RIS:   rdata <= {30'h0, ris_r};
                LWD_REG_MIS:   rdata <= {30'h0, ris_r & mask_r};
                LWD_REG_IMASK: rdata <= {30'h0, mask_r};
                LWD_REG_LOCK:  rdata <= ctl.rdata;
                default:       rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    AST_FIRST_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
        first_to |=> ris_r[LWD_ST_TIMEOUT]) else $error("first timeout lost");
    AST_RELOAD_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        at_zero && !wr_load |=> cnt_r == $past(load_r)) else $error("no reload");
    AST_IMM_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        wr_load && en_r |=> cnt_r == $past(wdata)) else $error("no immediate load");
    AST_ZERO_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
        zero_load |=> ris_r[LWD_ST_TIMEOUT]) else $error("zero reload no irq");
    AST_NO_RESET: assert property (@(posedge clk) disable iff (!rst_b)
        second_to && !resen_r && !cpu_reset |=> !cpu_reset) else $error("reset w/o enable");
    AST_RESET: assert property (@(posedge clk) disable iff (!rst_b)
        second_to && resen_r |=> cpu_reset) else $error("reset missing");
    AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_b)
        en_r && stall_r && dbg_halt && !wr_load |=> $stable(cnt_r))
        else $error("count moved in halt");
    AST_DECR: assert property (@(posedge clk) disable iff (!rst_b)
        tick && cnt_r != LWD_ZERO && !wr_load |=> cnt_r == $past(cnt_r) - 32'h1)
        else $error("no decrement");
    AST_LOCKED_CTRL: assert property (@(posedge clk) disable iff (!rst_b)
        ctl.locked |=> $stable(en_r) && $stable(resen_r) && $stable(load_r))
        else $error("config changed while locked");
    AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
        wr_icr && wdata[LWD_ST_TIMEOUT] && !at_zero && !zero_load |=> !ris_r[LWD_ST_TIMEOUT])
        else $error("clear ignored");
endmodule
`default_nettype wire

// File: dv/lwd_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lwd_pkg::*;
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [LWD_AW-1:0] addr = '0;
    logic [LWD_DW-1:0] wdata = '0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [LWD_DW-1:0] rdata;
    logic              dbg_halt = 1'b0;
    logic              irq;
    logic              cpu_reset;
    int                num_errors = 0;
    int                check_count = 0;
    int                n;
    logic [31:0]       seed = 32'hc11f;
    logic [31:0]       ld_m;
    logic [31:0]       v;
    logic [31:0]       w;

    always #2.5 clk = ~clk;

    lwd_top dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                 .rdata(rdata), .dbg_halt(dbg_halt), .irq(irq), .cpu_reset(cpu_reset));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic close_out();
        $display("Checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    // Callers sample after the edge has settled; got is copied on entry
    task automatic chk_pin(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_hi(input bit sel, input int lim, output int c);
        c = 0;
        while ((sel ? cpu_reset : irq) !== 1'b1) begin
            if (c >= lim) begin
                num_errors++;
                $display("Error %0t: wait timed out", $time);
                close_out();
            end
            @(posedge clk);
            c++;
        end
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(LWD_REG_LOAD, v);
        chk_reg(v, LWD_LOAD_RST);
        rd_reg(LWD_REG_CTRL, v);
        chk_reg(v, LWD_ZERO);
        rd_reg(LWD_REG_LOCK, v);
        chk_reg(v, LWD_ZERO);
        rd_reg(4'hf, v);
        chk_reg(v, LWD_ZERO);
        chk_pin(irq, 1'b0);
        $display("Test reset values done");
        seed = xs(seed);
        ld_m = seed | 32'h1000_0000;
        wr_reg(LWD_REG_LOAD, ld_m);
        rd_reg(LWD_REG_LOAD, v);
        chk_reg(v, ld_m);
        wr_reg(LWD_REG_LOCK, LWD_ZERO);
        rd_reg(LWD_REG_LOCK, v);
        chk_reg(v, 32'h1);
        seed = xs(seed);
        wr_reg(LWD_REG_LOAD, seed);
        wr_reg(LWD_REG_CTRL, 32'h7);
        rd_reg(LWD_REG_LOAD, v);
        chk_reg(v, ld_m);
        rd_reg(LWD_REG_CTRL, v);
        chk_reg(v, LWD_ZERO);
        // Unlock first, then enable with stall, then load
        wr_reg(LWD_REG_LOCK, LWD_UNLOCK_KEY);
        rd_reg(LWD_REG_LOCK, v);
        chk_reg(v, LWD_ZERO);
        $display("Test lock done");
        dbg_halt <= 1'b1;
        wr_reg(LWD_REG_CTRL, 32'h5);
        rd_reg(LWD_REG_CTRL, v);
        chk_reg(v, 32'h5);
        seed = xs(seed);
        ld_m = seed | 32'h1000_0000;
        wr_reg(LWD_REG_LOAD, ld_m);
        repeat (8) @(posedge clk);
        rd_reg(LWD_REG_VALUE, v);
        chk_reg(v, ld_m);
        dbg_halt <= 1'b0;
        repeat (20) @(posedge clk);
        dbg_halt <= 1'b1;
        rd_reg(LWD_REG_VALUE, v);
        chk_pin(v < ld_m && v > ld_m - 32'd40, 1'b1);
        // Stall bit off: halt no longer freezes the count
        wr_reg(LWD_REG_CTRL, 32'h1);
        rd_reg(LWD_REG_VALUE, v);
        rd_reg(LWD_REG_VALUE, w);
        chk_pin(w < v, 1'b1);
        $display("Test stall done");
        wr_reg(LWD_REG_LOAD, LWD_ZERO);
        chk_pin(irq, 1'b1);
        repeat (4) @(posedge clk);
        rd_reg(LWD_REG_RIS, v);
        chk_reg(v, 32'h3);
        rd_reg(LWD_REG_MIS, v);
        chk_reg(v, 32'h3);
        chk_pin(cpu_reset, 1'b0);
        wr_reg(LWD_REG_IMASK, LWD_ZERO);
        chk_pin(irq, 1'b0);
        rd_reg(LWD_REG_MIS, v);
        chk_reg(v, LWD_ZERO);
        wr_reg(LWD_REG_IMASK, 32'h3);
        wr_reg(LWD_REG_LOCK, LWD_ZERO);
        wr_reg(LWD_REG_ICR, 32'h3);
        rd_reg(LWD_REG_RIS, v);
        chk_reg(v, 32'h3);
        wr_reg(LWD_REG_LOCK, LWD_UNLOCK_KEY);
        wr_reg(LWD_REG_LOAD, 32'd40);
        wr_reg(LWD_REG_ICR, 32'h3);
        rd_reg(LWD_REG_RIS, v);
        chk_reg(v, LWD_ZERO);
        chk_pin(irq, 1'b0);
        wait_hi(1'b0, 60, n);
        chk_pin(n > 25, 1'b1);
        repeat (45) @(posedge clk);
        rd_reg(LWD_REG_RIS, v);
        chk_reg(v, 32'h3);
        chk_pin(cpu_reset, 1'b0);
        // Reset enable only bites on the next second timeout
        wr_reg(LWD_REG_CTRL, 32'h3);
        wait_hi(1'b1, 60, n);
        chk_pin(cpu_reset, 1'b1);
        $display("Test timeout done");
        close_out();
    end
endmodule
`default_nettype wire
